/* File: hw/mre_exec.sv */
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module mre_exec
   import mre_pkg::*;
(
   // Clock and reset
   input  wire logic                CLK,
   input  wire logic                RST,
   // Instruction stream
   input  wire logic                INSTR_VALID,
   input  wire logic [INSTR_W-1:0]  INSTR,
   output logic                     BUSY,
   // File register operand and write-back
   input  wire logic [DATA_W-1:0]   FILE_RDATA,
   output logic                     FILE_WE,
   output logic [FADDR_W-1:0]       FILE_WADDR,
   output logic [DATA_W-1:0]        FILE_WDATA,
   // Program flow
   input  wire logic [PC_W-1:0]     STACK_TOP,
   output logic                     STACK_POP,
   output logic                     PC_LOAD,
   output logic [PC_W-1:0]          PC_VALUE,
   // Core state
   output logic [DATA_W-1:0]        WORK,
   output logic                     ZERO,
   output logic [BANK_W-1:0]        BANK_SELECT,
   output logic [DATA_W-1:0]        OPTION_CFG,
   output logic                     GLOBAL_IRQ_ENABLE,
   // Register port
   input  wire logic [RADDR_W-1:0]  REG_ADDR,
   input  wire logic [DATA_W-1:0]   REG_WDATA,
   input  wire logic                REG_WR,
   input  wire logic                REG_RD,
   output logic [DATA_W-1:0]        REG_RDATA
);

   mre_dec_t           dec;
   logic               take;
   logic               is_ret;
   logic [DATA_W-1:0]  res;
   logic               res_valid;
   logic               res_zero_upd;
   logic               sw_wr;

   logic [DATA_W-1:0]  work_q;
   logic [DATA_W-1:0]  work_d;
   logic               zero_q;
   logic               zero_d;
   logic [BANK_W-1:0]  bank_q;
   logic [BANK_W-1:0]  bank_d;
   logic [DATA_W-1:0]  option_q;
   logic [DATA_W-1:0]  option_d;
   logic               irq_en_q;
   logic               irq_en_d;
   mre_fwr_t           fwr_q;
   mre_fwr_t           fwr_d;
   logic               busy_q;
   logic               pop_q;
   logic               pc_load_q;
   logic [PC_W-1:0]    pc_q;
   mre_op_t            last_op_q;
   logic [DATA_W-1:0]  rdata_q;
   logic [DATA_W-1:0]  rdata_d;

   mre_decoder u_dec (
      .instr (INSTR),
      .dec   (dec)
   );

   // Second cycle of a return discards the fetched word
   assign take   = INSTR_VALID && !busy_q;
   assign is_ret = (dec.op == OP_RETURN) || (dec.op == OP_RET_IRQ) ||
                   (dec.op == OP_RET_LIT);
   assign sw_wr  = REG_WR && !REG_RD;

   // Result path for the destination-bit instructions
   always_comb begin
      res          = FILE_RDATA;
      res_valid    = 1'b0;
      res_zero_upd = 1'b0;
      if (take) begin
         unique case (dec.op)
            OP_OR_WF: begin
               res          = work_q | FILE_RDATA; // RL1
               res_valid    = 1'b1;
               res_zero_upd = 1'b1;
            end
            OP_MOVE_FILE: begin
               res          = FILE_RDATA; // RL4 RL5
               res_valid    = 1'b1;
               res_zero_upd = 1'b1;
            end
            default: begin
               res          = FILE_RDATA;
               res_valid    = 1'b0;
               res_zero_upd = 1'b0;
            end
         endcase
      end
   end

   // Work register
   // Instruction result is applied last, so it wins over a software write
   always_comb begin
      work_d = work_q;
      if (sw_wr && REG_ADDR == REG_WORK) begin
         work_d = REG_WDATA;
      end
      if (res_valid && !dec.dest_file) begin
         work_d = res; // RL2
      end else if (take && dec.op == OP_LOAD_WORK) begin
         work_d = dec.lit; // RL8
      end else if (take && dec.op == OP_RET_LIT) begin
         work_d = dec.lit; // RL11
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         work_q <= RST_WORK;
      end else begin
         work_q <= work_d;
      end
   end

   // Zero flag, only OR and move-file touch it
   // Software write first, an instruction in the same cycle overrides it
   always_comb begin
      zero_d = zero_q;
      if (sw_wr && REG_ADDR == REG_STATUS) begin
         zero_d = REG_WDATA[ZERO_BIT];
      end
      if (res_zero_upd) begin
         zero_d = (res == '0); // RL12 RL1 RL4
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         zero_q <= RST_ZERO;
      end else begin
         zero_q <= zero_d;
      end
   end

   // Bank select
   // Only the low three literal bits reach the bank register
   always_comb begin
      bank_d = bank_q;
      if (sw_wr && REG_ADDR == REG_BANK) begin
         bank_d = REG_WDATA[BANK_W-1:0];
      end
      if (take && dec.op == OP_LOAD_BANK) begin
         bank_d = dec.lit[BANK_W-1:0]; // RL6
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         bank_q <= RST_BANK;
      end else begin
         bank_q <= bank_d;
      end
   end

   // Option configuration
   // Takes the work register as it stood before this edge
   always_comb begin
      option_d = option_q;
      if (sw_wr && REG_ADDR == REG_OPTION) begin
         option_d = REG_WDATA;
      end
      if (take && dec.op == OP_LOAD_OPTION) begin
         option_d = work_q; // RL7
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         option_q <= RST_OPTION;
      end else begin
         option_q <= option_d;
      end
   end

   // Global interrupt enable, set by return-from-interrupt
   // Set wins over a software clear in the same cycle
   always_comb begin
      irq_en_d = irq_en_q;
      if (sw_wr && REG_ADDR == REG_IRQ0) begin
         irq_en_d = REG_WDATA[IRQ_EN_BIT];
      end
      if (take && dec.op == OP_RET_IRQ) begin
         irq_en_d = 1'b1; // RL10
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         irq_en_q <= RST_IRQ_EN;
      end else begin
         irq_en_q <= irq_en_d;
      end
   end

   // File register write-back
   // Address from the decoded word and data from the result path (work register for move-work-to-file) are registered every cycle, the strobe lasts one cycle
   always_comb begin
      fwr_d.we   = 1'b0;
      fwr_d.addr = dec.faddr;
      fwr_d.data = res;
      if (res_valid && dec.dest_file) begin
         fwr_d.we = 1'b1; // RL2 RL5
      end else if (take && dec.op == OP_WORK_TO_F) begin
         fwr_d.we   = 1'b1;
         fwr_d.data = work_q; // RL3
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         fwr_q <= '0;
      end else begin
         fwr_q <= fwr_d;
      end
   end

   // Returns: pop and reload, then one discarded cycle
   // Reload address stands until the next return
   always_ff @(posedge CLK) begin
      if (RST) begin
         pop_q     <= 1'b0;
         pc_load_q <= 1'b0;
         pc_q      <= '0;
      end else begin
         pop_q     <= take && is_ret; // RL9
         pc_load_q <= take && is_ret;
         if (take && is_ret) begin
            pc_q <= STACK_TOP; // RL9
         end
      end
   end

   // Busy marks the discarded second cycle of a return
   always_ff @(posedge CLK) begin
      if (RST) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= take && is_ret && (RET_CYCLES > 1); // RL9
      end
   end

   // Last taken operation, shown in the exec status register
   always_ff @(posedge CLK) begin
      if (RST) begin
         last_op_q <= OP_NONE;
      end else if (take) begin
         last_op_q <= dec.op;
      end
   end

   // Register read, data one cycle after the strobe
   // Idle cycles and unmapped addresses read zero
   always_comb begin
      rdata_d = '0;
      if (REG_RD) begin
         unique case (REG_ADDR)
            REG_WORK:   rdata_d = work_q;
            REG_STATUS: rdata_d[ZERO_BIT] = zero_q;
            REG_BANK:   rdata_d[BANK_W-1:0] = bank_q;
            REG_OPTION: rdata_d = option_q;
            REG_IRQ0:   rdata_d[IRQ_EN_BIT] = irq_en_q;
            REG_EXEC: begin
               rdata_d[BUSY_BIT] = busy_q;
               rdata_d[3:0]      = last_op_q;
            end
            default:    rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign BUSY              = busy_q;
   assign FILE_WE           = fwr_q.we;
   assign FILE_WADDR        = fwr_q.addr;
   assign FILE_WDATA        = fwr_q.data;
   assign STACK_POP         = pop_q;
   assign PC_LOAD           = pc_load_q;
   assign PC_VALUE          = pc_q;
   assign WORK              = work_q;
   assign ZERO              = zero_q;
   assign BANK_SELECT       = bank_q;
   assign OPTION_CFG        = option_q;
   assign GLOBAL_IRQ_ENABLE = irq_en_q;
   assign REG_RDATA         = rdata_q;

endmodule

/* File: hw/mre_pkg.sv */
// Operation
// RL1 - The OR-with-file instruction ORs the work register with the file operand and updates only the zero flag.
// RL2 - A destination bit of zero sends the result to the work register, a one sends it back to the file register.
// RL3 - Move-work-to-file copies the work register into file register 0 to 31 and leaves every flag alone.
// RL4 - Move-file copies the file register to the chosen destination and updates the zero flag from the value.
// RL5 - Move-file with destination one rewrites the same value, so the zero flag tests the register.
// RL6 - The bank literal instruction loads a 3-bit value 0 to 7 into the bank select register, no flag changes.
// RL7 - The load-option instruction copies the work register into the option register, no flag changes.
// RL8 - The work literal instruction loads an 8-bit value into the work register, no flag changes.
// RL9 - Each return reloads the program counter from the popped stack top, takes two cycles, changes no flag.
// RL10 - Return-from-interrupt also sets the global interrupt enable bit of the first interrupt control register.
// RL11 - Return-with-literal loads its 8-bit literal into the work register while it returns.
// RL12 - Where the zero flag is affected it is set for an all-zero 8-bit result and cleared otherwise.
package mre_pkg;

   localparam int DATA_W  = 8;
   localparam int FADDR_W = 5;
   localparam int BANK_W  = 3;
   localparam int INSTR_W = 12;
   localparam int PC_W    = 11;
   localparam int RADDR_W = 3;

   // Opcode masks and match values
   localparam logic [INSTR_W-1:0] MASK_FULL   = 12'hFFF;
   localparam logic [INSTR_W-1:0] MASK_W2F    = 12'hFE0;
   localparam logic [INSTR_W-1:0] MASK_FDEST  = 12'hFC0;
   localparam logic [INSTR_W-1:0] MASK_BANK   = 12'hFF8;
   localparam logic [INSTR_W-1:0] MASK_LIT    = 12'hF00;
   localparam logic [INSTR_W-1:0] CODE_W2F    = 12'h020;
   localparam logic [INSTR_W-1:0] CODE_OR_WF  = 12'h100;
   localparam logic [INSTR_W-1:0] CODE_MOV_F  = 12'h200;
   localparam logic [INSTR_W-1:0] CODE_OPTION = 12'h002;
   localparam logic [INSTR_W-1:0] CODE_BANK   = 12'h010;
   localparam logic [INSTR_W-1:0] CODE_RET    = 12'h01E;
   localparam logic [INSTR_W-1:0] CODE_RETIRQ = 12'h01F;
   localparam logic [INSTR_W-1:0] CODE_RETLIT = 12'h800;
   localparam logic [INSTR_W-1:0] CODE_LDLIT  = 12'hC00;
   localparam int DEST_BIT = 5;

   // Register port map
   localparam logic [RADDR_W-1:0] REG_WORK   = 3'h0;
   localparam logic [RADDR_W-1:0] REG_STATUS = 3'h1;
   localparam logic [RADDR_W-1:0] REG_BANK   = 3'h2;
   localparam logic [RADDR_W-1:0] REG_OPTION = 3'h3;
   localparam logic [RADDR_W-1:0] REG_IRQ0   = 3'h4;
   localparam logic [RADDR_W-1:0] REG_EXEC   = 3'h5;
   localparam int ZERO_BIT   = 2;
   localparam int IRQ_EN_BIT = 7;
   localparam int BUSY_BIT   = 7;

   // Reset values
   localparam logic [DATA_W-1:0] RST_WORK   = 8'h00;
   localparam logic [DATA_W-1:0] RST_OPTION = 8'hFF;
   localparam logic [BANK_W-1:0] RST_BANK   = 3'h0;
   localparam logic              RST_ZERO   = 1'b0;
   localparam logic              RST_IRQ_EN = 1'b0;

   // Return instructions occupy two cycles
   localparam int RET_CYCLES = 2;

   typedef enum logic [3:0] {
      OP_NONE        = 4'h0,
      OP_OR_WF       = 4'h1,
      OP_WORK_TO_F   = 4'h2,
      OP_MOVE_FILE   = 4'h3,
      OP_LOAD_BANK   = 4'h4,
      OP_LOAD_OPTION = 4'h5,
      OP_LOAD_WORK   = 4'h6,
      OP_RETURN      = 4'h7,
      OP_RET_IRQ     = 4'h8,
      OP_RET_LIT     = 4'h9
   } mre_op_t;

   typedef struct packed {
      mre_op_t             op;
      logic                dest_file;
      logic [FADDR_W-1:0]  faddr;
      logic [DATA_W-1:0]   lit;
   } mre_dec_t;

   typedef struct packed {
      logic                we;
      logic [FADDR_W-1:0]  addr;
      logic [DATA_W-1:0]   data;
   } mre_fwr_t;

endpackage

/* File: hw/mre_decoder.sv */
`timescale 1ns/100ps
module mre_decoder
   import mre_pkg::*;
(
   // Instruction word
   input  wire logic [INSTR_W-1:0] instr,
   // Decoded fields
   output mre_dec_t                dec
);

   function automatic logic hit(input logic [INSTR_W-1:0] w,
                                input logic [INSTR_W-1:0] m,
                                input logic [INSTR_W-1:0] c);
      hit = ((w & m) == c);
   endfunction

   always_comb begin
      dec.dest_file = instr[DEST_BIT];
      dec.faddr     = instr[FADDR_W-1:0];
      dec.lit       = instr[DATA_W-1:0];
      if (hit(instr, MASK_FDEST, CODE_OR_WF)) begin
         dec.op = OP_OR_WF;
      end else if (hit(instr, MASK_W2F, CODE_W2F)) begin
         dec.op = OP_WORK_TO_F;
      end else if (hit(instr, MASK_FDEST, CODE_MOV_F)) begin
         dec.op = OP_MOVE_FILE;
      end else if (hit(instr, MASK_BANK, CODE_BANK)) begin
         dec.op = OP_LOAD_BANK;
      end else if (hit(instr, MASK_FULL, CODE_OPTION)) begin
         dec.op = OP_LOAD_OPTION;
      end else if (hit(instr, MASK_LIT, CODE_LDLIT)) begin
         dec.op = OP_LOAD_WORK;
      end else if (hit(instr, MASK_FULL, CODE_RET)) begin
         dec.op = OP_RETURN;
      end else if (hit(instr, MASK_FULL, CODE_RETIRQ)) begin
         dec.op = OP_RET_IRQ;
      end else if (hit(instr, MASK_LIT, CODE_RETLIT)) begin
         dec.op = OP_RET_LIT;
      end else begin
         dec.op = OP_NONE;
      end
   end

endmodule

/* File: testbench/mre_exec_checker.sv */
`timescale 1ns/100ps
module mre_exec_checker
   import mre_pkg::*;
(
   // Clock and reset
   input wire logic               CLK,
   input wire logic               RST,
   // Instruction side
   input wire logic               INSTR_VALID,
   input wire logic [INSTR_W-1:0] INSTR,
   input wire logic               BUSY,
   input wire logic [DATA_W-1:0]  FILE_RDATA,
   input wire logic [PC_W-1:0]    STACK_TOP,
   input wire logic               REG_WR,
   // Results
   input wire logic               FILE_WE,
   input wire logic [FADDR_W-1:0] FILE_WADDR,
   input wire logic [DATA_W-1:0]  FILE_WDATA,
   input wire logic               STACK_POP,
   input wire logic               PC_LOAD,
   input wire logic [PC_W-1:0]    PC_VALUE,
   input wire logic [DATA_W-1:0]  WORK,
   input wire logic               ZERO,
   input wire logic [BANK_W-1:0]  BANK_SELECT,
   input wire logic [DATA_W-1:0]  OPTION_CFG,
   input wire logic               GLOBAL_IRQ_ENABLE
);
   logic [INSTR_W-1:0] ins_q;
   logic [DATA_W-1:0]  work_q;
   logic [DATA_W-1:0]  fd_q;
   logic [PC_W-1:0]    top_q;
   // Operands as they stood at the taking edge
   always_ff @(posedge CLK) begin
      ins_q  <= INSTR;
      work_q <= WORK;
      fd_q   <= FILE_RDATA;
      top_q  <= STACK_TOP;
   end
   // Software writes excluded so flag checks stay fair
   wire take    = INSTR_VALID && !BUSY && !REG_WR;
   wire is_or   = take && ((INSTR & MASK_FDEST) == CODE_OR_WF);
   wire is_move_file = take && ((INSTR & MASK_FDEST) == CODE_MOV_F);
   wire is_w2f  = take && ((INSTR & MASK_W2F) == CODE_W2F);
   wire is_bank = take && ((INSTR & MASK_BANK) == CODE_BANK);
   wire is_lit  = take && ((INSTR & MASK_LIT) == CODE_LDLIT);
   wire is_rlit = take && ((INSTR & MASK_LIT) == CODE_RETLIT);
   wire is_rirq = take && (INSTR == CODE_RETIRQ);
   wire is_ret  = is_rlit || is_rirq || (take && (INSTR == CODE_RET));
   // Any taken return, software writes included
   wire ret_any = INSTR_VALID && !BUSY && (INSTR == CODE_RET || INSTR == CODE_RETIRQ ||
      (INSTR & MASK_LIT) == CODE_RETLIT);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   sequence ret_first;
      STACK_POP && PC_LOAD && BUSY && PC_VALUE == top_q && $stable(ZERO);
   endsequence
   sequence ret_second;
      !BUSY && !STACK_POP && !PC_LOAD && $stable(ZERO);
   endsequence
   or_work_a: assert property (is_or && !INSTR[DEST_BIT] |=>
      WORK == (work_q | fd_q) && ZERO == ((work_q | fd_q) == 8'h00))
      else $error("or into work wrong");
   or_file_a: assert property (is_or && INSTR[DEST_BIT] |=> FILE_WE &&
      FILE_WADDR == ins_q[4:0] && FILE_WDATA == (work_q | fd_q) && WORK == work_q)
      else $error("or into file wrong");
   work_file_a: assert property (is_w2f |=> FILE_WE && FILE_WDATA == work_q &&
      FILE_WADDR == ins_q[4:0] && $stable(ZERO)) else $error("work to file wrong");
   move_file_a: assert property (is_move_file |=> ZERO == (fd_q == 8'h00) &&
      (ins_q[DEST_BIT] ? FILE_WE && FILE_WDATA == fd_q : WORK == fd_q && !FILE_WE))
      else $error("move file wrong");
   bank_load_a: assert property (is_bank |=>
      BANK_SELECT == ins_q[2:0] && $stable(ZERO)) else $error("bank load wrong");
   option_load_a: assert property (take && INSTR == CODE_OPTION |=>
      OPTION_CFG == work_q && $stable(ZERO)) else $error("option load wrong");
   work_literal_a: assert property (is_lit |=>
      WORK == ins_q[7:0] && $stable(ZERO)) else $error("work literal wrong");
   return_two_a: assert property (is_ret |=> ret_first ##1 ret_second)
      else $error("return sequence wrong");
   irq_enable_a: assert property (is_rirq |=> GLOBAL_IRQ_ENABLE)
      else $error("irq enable not set");
   return_lit_a: assert property (is_rlit |=> WORK == ins_q[7:0])
      else $error("return literal wrong");
   pop_cause_a: assert property (STACK_POP |-> $past(ret_any))
      else $error("pop without return");
endmodule

/* File: testbench/mre_exec_tb_top.sv */
`timescale 1ns/100ps
module mre_exec_tb_top;
   import mre_pkg::*;
   logic               CLK;
   logic               RST = 1'b1;
   logic               INSTR_VALID = 1'b0;
   logic [INSTR_W-1:0] INSTR = 12'h000;
   logic               BUSY;
   logic [DATA_W-1:0]  FILE_RDATA = 8'h00;
   logic               FILE_WE;
   logic [FADDR_W-1:0] FILE_WADDR;
   logic [DATA_W-1:0]  FILE_WDATA;
   logic [PC_W-1:0]    STACK_TOP = 11'h000;
   logic               STACK_POP;
   logic               PC_LOAD;
   logic [PC_W-1:0]    PC_VALUE;
   logic [DATA_W-1:0]  WORK;
   logic               ZERO;
   logic [BANK_W-1:0]  BANK_SELECT;
   logic [DATA_W-1:0]  OPTION_CFG;
   logic               GLOBAL_IRQ_ENABLE;
   logic [RADDR_W-1:0] REG_ADDR = 3'h0;
   logic [DATA_W-1:0]  REG_WDATA = 8'h00;
   logic               REG_WR = 1'b0;
   logic               REG_RD = 1'b0;
   logic [DATA_W-1:0]  REG_RDATA;
   int                 err_count = 0;
   int                 n_checks = 0;
   mre_exec dut (.CLK(CLK), .RST(RST), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
      .BUSY(BUSY), .FILE_RDATA(FILE_RDATA), .FILE_WE(FILE_WE), .FILE_WADDR(FILE_WADDR),
      .FILE_WDATA(FILE_WDATA), .STACK_TOP(STACK_TOP), .STACK_POP(STACK_POP),
      .PC_LOAD(PC_LOAD), .PC_VALUE(PC_VALUE), .WORK(WORK), .ZERO(ZERO),
      .BANK_SELECT(BANK_SELECT), .OPTION_CFG(OPTION_CFG),
      .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));
   initial begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic op(input logic [11:0] i, input logic [7:0] fd);
      @(posedge CLK);
      INSTR_VALID <= 1'b1;
      INSTR <= i;
      FILE_RDATA <= fd;
      @(posedge CLK);
      INSTR_VALID <= 1'b0;
      #1;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge CLK);
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge CLK);
      REG_WR <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge CLK);
      REG_RD <= 1'b1;
      REG_ADDR <= a;
      @(posedge CLK);
      REG_RD <= 1'b0;
      #1;
      chk(REG_RDATA, exp);
   endtask
   task automatic complete_run;
      if (err_count == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic t_reset;
      #1;
      chk(WORK, 8'h00);
      chk(OPTION_CFG, 8'hFF);
      chk(GLOBAL_IRQ_ENABLE, 1'b0);
   endtask
   task automatic t_move_file;
      op(CODE_LDLIT | 12'h033, 8'h00);
      op(CODE_MOV_F | 12'h005, 8'h00);
      chk(WORK, 8'h00);
      chk(ZERO, 1'b1);
      op(CODE_MOV_F | 12'h03F, 8'h5A);
      chk(FILE_WE, 1'b1);
      chk(FILE_WDATA, 8'h5A);
      chk(ZERO, 1'b0);
      chk(WORK, 8'h00);
   endtask
   task automatic t_or;
      op(CODE_LDLIT | 12'h00F, 8'h00);
      op(CODE_OR_WF | 12'h003, 8'hF0);
      chk(WORK, 8'hFF);
      chk(ZERO, 1'b0);
      op(CODE_LDLIT | 12'h000, 8'h00);
      op(CODE_OR_WF | 12'h03F, 8'h00);
      chk(FILE_WADDR, 5'h1F);
      chk(ZERO, 1'b1);
   endtask
   task automatic t_literal_file;
      op(CODE_LDLIT | 12'h0FF, 8'h00);
      chk(WORK, 8'hFF);
      chk(ZERO, 1'b1);
      op(CODE_W2F | 12'h01F, 8'h00);
      chk(FILE_WDATA, 8'hFF);
      chk(ZERO, 1'b1);
      for (int k = 0; k < 8; k++) begin
         op(CODE_BANK | 12'(k), 8'h00);
         chk(BANK_SELECT, 11'(k));
      end
      op(CODE_LDLIT | 12'h081, 8'h00);
      op(CODE_OPTION, 8'h00);
      chk(OPTION_CFG, 8'h81);
      chk(ZERO, 1'b1);
   endtask
   task automatic t_returns;
      logic [11:0] codes [3] = '{CODE_RET, CODE_RETIRQ, CODE_RETLIT | 12'h0A5};
      logic [10:0] tops [3] = '{11'h123, 11'h7FF, 11'h400};
      for (int i = 0; i < 3; i++) begin
         op(CODE_LDLIT | 12'h011, 8'h00);
         @(posedge CLK);
         INSTR_VALID <= 1'b1;
         INSTR <= codes[i];
         STACK_TOP <= tops[i];
         @(posedge CLK);
         INSTR <= CODE_LDLIT | 12'h099;
         #1;
         chk(STACK_POP, 1'b1);
         chk(BUSY, 1'b1);
         chk(PC_VALUE, tops[i]);
         chk(WORK, (i == 2) ? 8'hA5 : 8'h11);
         @(posedge CLK);
         INSTR_VALID <= 1'b0;
         #1;
         chk(PC_LOAD, 1'b0);
         chk(WORK, (i == 2) ? 8'hA5 : 8'h11);
         chk(GLOBAL_IRQ_ENABLE, i > 0);
      end
   endtask
   task automatic t_regs;
      wr(REG_WORK, 8'h77);
      rd(REG_WORK, 8'h77);
      rd(3'h6, 8'h00);
      rd(REG_BANK, 8'h07);
      wr(3'h7, 8'h55);
      rd(REG_IRQ0, 8'h80);
      rd(REG_STATUS, 8'h04);
      wr(REG_STATUS, 8'h00);
      rd(REG_STATUS, 8'h00);
      wr(REG_OPTION, 8'h3C);
      rd(REG_OPTION, 8'h3C);
      rd(REG_EXEC, 8'h09);
      wr(REG_IRQ0, 8'h00);
      rd(REG_IRQ0, 8'h00);
   endtask
   initial begin
      repeat (16) @(posedge CLK);
      RST <= 1'b0;
      t_reset();
      t_move_file();
      t_or();
      t_literal_file();
      t_returns();
      t_regs();
      complete_run();
   end
endmodule
bind mre_exec mre_exec_checker u_chk (.CLK(CLK), .RST(RST), .INSTR_VALID(INSTR_VALID),
   .INSTR(INSTR), .BUSY(BUSY), .FILE_RDATA(FILE_RDATA), .STACK_TOP(STACK_TOP),
   .REG_WR(REG_WR), .FILE_WE(FILE_WE), .FILE_WADDR(FILE_WADDR), .FILE_WDATA(FILE_WDATA),
   .STACK_POP(STACK_POP), .PC_LOAD(PC_LOAD), .PC_VALUE(PC_VALUE), .WORK(WORK),
   .ZERO(ZERO), .BANK_SELECT(BANK_SELECT), .OPTION_CFG(OPTION_CFG),
   .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE));
